// ---- dce_pkg.sv ----
package dce_pkg;

  // ************************************************************
  // Command codes
  // ************************************************************
  localparam logic [7:0] CMD_ERASE    = 8'h14;
  localparam logic [7:0] CMD_WR_CFG   = 8'h1D;
  localparam logic [7:0] CMD_RD_CFG   = 8'h24;
  localparam logic [7:0] CMD_PC       = 8'h28;
  localparam logic [7:0] CMD_STATUS   = 8'h34;
  localparam logic [7:0] CMD_BP       = 8'h3B;
  localparam logic [7:0] CMD_HALT     = 8'h44;
  localparam logic [7:0] CMD_RESUME   = 8'h4C;
  localparam logic [7:0] CMD_INJECT   = 8'h54;
  localparam logic [7:0] CMD_STEP     = 8'h5C;
  localparam logic [7:0] CMD_REPLACE  = 8'h64;
  localparam logic [7:0] CMD_ID       = 8'h68;
  localparam logic [7:0] CMD_LEN_MASK = 8'hFC;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int BP_SLOTS      = 4;
  localparam int BP_SLOT_HI    = 4;
  localparam int BP_SLOT_LO    = 3;
  localparam int BP_EN_BIT     = 2;
  localparam int ST_ERASE_DONE = 7;
  localparam int ST_CPU_IDLE   = 6;
  localparam int ST_HALTED     = 5;
  localparam int ST_PM0        = 4;
  localparam int ST_CAUSE      = 3;
  localparam int ST_LOCKED     = 2;
  localparam int ST_OSC_STABLE = 1;

  // ************************************************************
  // Reset values and counts
  // ************************************************************
  localparam logic [7:0]  CFG_RESET     = 8'h00;
  localparam logic [15:0] BP_ADDR_RESET = 16'h0000;
  localparam logic [4:0]  BITS_ONE_BYTE = 5'h08;
  localparam logic [4:0]  BITS_TWO_BYTE = 5'h10;

  typedef enum logic [1:0] {
    DCE_CMD,
    DCE_ARGS,
    DCE_RESP
  } dce_state_e;

endpackage

// ---- dce_engine.sv ----
`timescale 1ns/100ps

// How it works
// - Status query returns the one-byte debug status word
// - Four independent breakpoint slots, numbered zero to three
// - Enabled slot matching the code address bus stops the CPU
// - Control bits 4:3 pick slot, bit 2 enables, others ignored
// - Second byte is address high half, third byte address low half
// - Mass erase sets flash to ones, returns status; a cleared lock bit is kept until reset
// - Configuration write stores next byte, returns status
// - Configuration read returns the last stored configuration byte
// - Program counter query returns sixteen bits as two bytes
// - Halt stops the CPU and returns status
// - Resume restarts a stopped CPU and returns status
// - Injection runs host bytes without moving the counter, returns status
// - Low two code bits give instruction length; zero is invalid
// - Single step runs next fetched instruction, returns status
// - Step with replace runs host instruction instead, returns status
// - Identity query returns part number byte then revision byte
// - Data driven on debug clock rise, sampled on its fall
// - One to four host bytes, one or two reply bytes, MSB first
// - When lock bit cleared only erase, status, identity are served
// - Status bit 7 is erase done; others CPU idle, halt, power mode 0, cause, lock, oscillator stable
module dce_engine #(
  parameter logic [7:0] PART_CODE = 8'hA5, // Arbitrary value
  parameter logic [7:0] REV_CODE  = 8'h01  // Arbitrary value
) (
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic        clk_en,
  input  wire logic        debug_clock_pin,
  input  wire logic        debug_io_pin_i,
  output logic             debug_io_pin_o,
  output logic             debug_io_pin_oe,
  input  wire logic [15:0] cpu_code_addr,
  input  wire logic [15:0] cpu_pc,
  input  wire logic        cpu_idle,
  input  wire logic        power_mode_0,
  input  wire logic        osc_stable,
  input  wire logic        erase_busy,
  input  wire logic        debug_access_lock,
  output logic             cpu_halted,
  output logic             halt_cause_bp,
  output logic             cpu_step_req,
  output logic             cpu_inject_req,
  output logic             cpu_inject_replace,
  output logic [1:0]       cpu_inject_len,
  output logic [23:0]      cpu_inject_data,
  output logic             flash_erase_req,
  output logic [7:0]       debug_cfg
);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic                   ck_s1;
    logic                   ck_s2;
    logic                   ck_s3;
    logic                   io_s1;
    logic                   io_s2;
    dce_pkg::dce_state_e    st;
    logic [2:0]             bitc;
    logic [7:0]             rx;
    logic [7:0]             cmd;
    logic [1:0]             argc;
    logic [23:0]            args;
    logic [15:0]            tx;
    logic [4:0]             txn;
    logic                   io_o;
    logic                   io_oe;
    logic                   init;
    logic                   lock;
    logic                   halted;
    logic                   cause;
    logic [7:0]             cfg;
    logic [3:0]             bp_en;
    logic [3:0][15:0]       bp_addr;
    logic                   step_req;
    logic                   inject_req;
    logic                   replace;
    logic [1:0]             inj_len;
    logic [23:0]            inj_data;
    logic                   erase_req;
  } dce_state_s;

  dce_state_s s_q;
  dce_state_s s_d;

  // ************************************************************
  // Command decode
  // ************************************************************
  function automatic logic is_inject(input logic [7:0] c);
    is_inject = ((c & dce_pkg::CMD_LEN_MASK) == dce_pkg::CMD_INJECT) ||
                ((c & dce_pkg::CMD_LEN_MASK) == dce_pkg::CMD_REPLACE);
  endfunction
  function automatic logic [1:0] arg_count(input logic [7:0] c);
    if (c == dce_pkg::CMD_BP)
      arg_count = 2'd3;
    else if (c == dce_pkg::CMD_WR_CFG)
      arg_count = 2'd1;
    else if (is_inject(c))
      arg_count = c[1:0];
    else
      arg_count = 2'd0;
  endfunction
  function automatic logic cmd_known(input logic [7:0] c);
    unique case (c)
      dce_pkg::CMD_ERASE, dce_pkg::CMD_WR_CFG, dce_pkg::CMD_RD_CFG,
      dce_pkg::CMD_PC, dce_pkg::CMD_STATUS, dce_pkg::CMD_BP,
      dce_pkg::CMD_HALT, dce_pkg::CMD_RESUME, dce_pkg::CMD_STEP,
      dce_pkg::CMD_ID:
        cmd_known = 1'b1;
      default:
        cmd_known = is_inject(c) && (c[1:0] != 2'b00);
    endcase
  endfunction
  function automatic logic cmd_allowed(input logic [7:0] c,
                                       input logic lock);
    cmd_allowed = cmd_known(c) &&
                  (lock || c == dce_pkg::CMD_ERASE ||
                   c == dce_pkg::CMD_STATUS || c == dce_pkg::CMD_ID);
  endfunction

  // ************************************************************
  // Link sampling
  // ************************************************************
  logic        rise;
  logic        fall;
  logic [7:0]  rx_byte;
  logic        byte_done;
  logic [7:0]  cmd_now;
  logic [23:0] args_now;
  logic        exec_now;
  logic [7:0]  ctrl;
  logic [1:0]  slot;
  logic        bp_hit;
  logic [7:0]  status;

  assign rise      = s_q.ck_s2 & ~s_q.ck_s3;
  assign fall      = ~s_q.ck_s2 & s_q.ck_s3;
  assign rx_byte   = {s_q.rx[6:0], s_q.io_s2};
  assign byte_done = fall && s_q.st != dce_pkg::DCE_RESP && s_q.bitc == 3'd7;
  assign cmd_now   = (s_q.st == dce_pkg::DCE_CMD) ? rx_byte : s_q.cmd;
  assign args_now  = (s_q.st == dce_pkg::DCE_CMD) ? 24'h00_0000
                                                  : {s_q.args[15:0], rx_byte};
  assign exec_now  = byte_done &&
                     ((s_q.st == dce_pkg::DCE_CMD &&
                       cmd_allowed(rx_byte, s_q.lock) &&
                       arg_count(rx_byte) == 2'd0) ||
                      (s_q.st == dce_pkg::DCE_ARGS && s_q.argc == 2'd1));
  assign ctrl      = args_now[23:16];
  assign slot      = ctrl[dce_pkg::BP_SLOT_HI:dce_pkg::BP_SLOT_LO];

  // Comparison runs every cycle; a hit is taken only in cycles with clk_en high
  always_comb
  begin
    bp_hit = 1'b0;
    for (int i = 0; i < dce_pkg::BP_SLOTS; i++)
      if (s_q.bp_en[i] && s_q.bp_addr[i] == cpu_code_addr)
        bp_hit = 1'b1;
  end

  always_comb
  begin
    status = 8'h00;
    status[dce_pkg::ST_ERASE_DONE] = ~erase_busy;
    status[dce_pkg::ST_CPU_IDLE]   = cpu_idle;
    status[dce_pkg::ST_HALTED]     = s_q.halted;
    status[dce_pkg::ST_PM0]        = power_mode_0;
    status[dce_pkg::ST_CAUSE]      = s_q.cause;
    status[dce_pkg::ST_LOCKED]     = ~s_q.lock;
    status[dce_pkg::ST_OSC_STABLE] = osc_stable;
  end

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb
  begin
    s_d            = s_q;
    s_d.ck_s1      = debug_clock_pin;
    s_d.ck_s2      = s_q.ck_s1;
    s_d.ck_s3      = s_q.ck_s2;
    s_d.io_s1      = debug_io_pin_i;
    s_d.io_s2      = s_q.io_s1;
    s_d.step_req   = 1'b0;
    s_d.inject_req = 1'b0;
    s_d.erase_req  = 1'b0;
    // Lock is taken once after reset, then only on CPU commands
    if (!s_q.init)
    begin
      s_d.init = 1'b1;
      s_d.lock = debug_access_lock;
    end
    if (fall && s_q.st != dce_pkg::DCE_RESP)
    begin
      s_d.rx   = rx_byte;
      s_d.bitc = s_q.bitc + 3'd1;
      if (s_q.bitc == 3'd7)
      begin
        if (s_q.st == dce_pkg::DCE_CMD)
        begin
          s_d.cmd = rx_byte;
          if (cmd_allowed(rx_byte, s_q.lock) && arg_count(rx_byte) != 2'd0)
          begin
            s_d.st   = dce_pkg::DCE_ARGS;
            s_d.argc = arg_count(rx_byte);
          end
        end
        else
        begin
          s_d.args = {s_q.args[15:0], rx_byte};
          s_d.argc = s_q.argc - 2'd1;
        end
      end
    end
    if (exec_now)
    begin
      s_d.st    = dce_pkg::DCE_RESP;
      s_d.io_oe = 1'b1;
      s_d.bitc  = 3'd0;
      s_d.txn   = dce_pkg::BITS_ONE_BYTE;
      s_d.tx    = {status, 8'h00};
      if (is_inject(cmd_now))
      begin
        s_d.inject_req = 1'b1;
        s_d.replace    = (cmd_now & dce_pkg::CMD_LEN_MASK) ==
                         dce_pkg::CMD_REPLACE;
        s_d.inj_len    = cmd_now[1:0];
        s_d.inj_data   = args_now;
        s_d.lock       = debug_access_lock;
      end
      else
      begin
        unique case (cmd_now)
          dce_pkg::CMD_ERASE:
            s_d.erase_req = 1'b1;
          dce_pkg::CMD_WR_CFG:
            s_d.cfg = args_now[7:0];
          dce_pkg::CMD_RD_CFG:
            s_d.tx = {s_q.cfg, 8'h00};
          dce_pkg::CMD_PC:
          begin
            s_d.tx  = cpu_pc;
            s_d.txn = dce_pkg::BITS_TWO_BYTE;
          end
          dce_pkg::CMD_ID:
          begin
            s_d.tx  = {PART_CODE, REV_CODE};
            s_d.txn = dce_pkg::BITS_TWO_BYTE;
          end
          dce_pkg::CMD_BP:
          begin
            s_d.bp_en[slot]   = ctrl[dce_pkg::BP_EN_BIT];
            s_d.bp_addr[slot] = args_now[15:0];
          end
          dce_pkg::CMD_HALT:
          begin
            s_d.halted = 1'b1;
            s_d.cause  = 1'b0;
            s_d.lock   = debug_access_lock;
          end
          dce_pkg::CMD_RESUME:
          begin
            s_d.halted = 1'b0;
            s_d.lock   = debug_access_lock;
          end
          dce_pkg::CMD_STEP:
          begin
            s_d.step_req = 1'b1;
            s_d.lock     = debug_access_lock;
          end
          default: ;
        endcase
      end
    end
    // Reply: bit out on rise, host takes it on the next fall
    if (s_q.st == dce_pkg::DCE_RESP)
    begin
      if (rise && s_q.txn != 5'd0)
      begin
        s_d.io_o = s_q.tx[15];
        s_d.tx   = {s_q.tx[14:0], 1'b0};
        s_d.txn  = s_q.txn - 5'd1;
      end
      else if (fall && s_q.txn == 5'd0)
      begin
        s_d.st    = dce_pkg::DCE_CMD;
        s_d.io_oe = 1'b0;
        s_d.io_o  = 1'b0;
      end
    end
    // A hit outranks a halt command in the same cycle
    if (bp_hit && !s_q.halted)
    begin
      s_d.halted = 1'b1;
      s_d.cause  = 1'b1;
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      s_q <= '0;
    else if (clk_en)
      s_q <= s_d;
  end

  assign debug_io_pin_o     = s_q.io_o;
  assign debug_io_pin_oe    = s_q.io_oe;
  assign cpu_halted         = s_q.halted;
  assign halt_cause_bp      = s_q.cause;
  assign cpu_step_req       = s_q.step_req;
  assign cpu_inject_req     = s_q.inject_req;
  assign cpu_inject_replace = s_q.replace;
  assign cpu_inject_len     = s_q.inj_len;
  assign cpu_inject_data    = s_q.inj_data;
  assign flash_erase_req    = s_q.erase_req;
  assign debug_cfg          = s_q.cfg;

  // ************************************************************
  // Checks
  // ************************************************************
  a_oe_only_reply: assert property (@(posedge mclk) disable iff (!resetn)
    debug_io_pin_oe |-> s_q.st == dce_pkg::DCE_RESP)
    else $error("Data pin driven outside a reply");
  a_bp_stop_cpu: assert property (@(posedge mclk) disable iff (!resetn)
    (clk_en && bp_hit && !cpu_halted) |=> (cpu_halted && halt_cause_bp))
    else $error("Breakpoint hit did not halt the CPU");
  a_reply_msb: assert property (@(posedge mclk) disable iff (!resetn)
    (clk_en && rise && s_q.st == dce_pkg::DCE_RESP && s_q.txn != 5'd0)
    |=> debug_io_pin_o == $past(s_q.tx[15]))
    else $error("Reply bit not sent MSB first");
  a_lock_ignore: assert property (@(posedge mclk) disable iff (!resetn)
    (clk_en && byte_done && s_q.st == dce_pkg::DCE_CMD && !s_q.lock &&
     rx_byte != dce_pkg::CMD_ERASE && rx_byte != dce_pkg::CMD_STATUS &&
     rx_byte != dce_pkg::CMD_ID)
    |=> (s_q.st == dce_pkg::DCE_CMD && !debug_io_pin_oe))
    else $error("Locked command was served");
  a_halt_cmd: assert property (@(posedge mclk) disable iff (!resetn)
    (clk_en && exec_now && cmd_now == dce_pkg::CMD_HALT) |=> cpu_halted)
    else $error("Halt command did not stop the CPU");
  a_cfg_write: assert property (@(posedge mclk) disable iff (!resetn)
    (clk_en && exec_now && cmd_now == dce_pkg::CMD_WR_CFG)
    |=> debug_cfg == $past(rx_byte))
    else $error("Configuration byte not stored");
  a_pc_reply: assert property (@(posedge mclk) disable iff (!resetn)
    (clk_en && exec_now && cmd_now == dce_pkg::CMD_PC)
    |=> (s_q.tx == $past(cpu_pc) && s_q.txn == dce_pkg::BITS_TWO_BYTE))
    else $error("Program counter reply wrong");
  a_erase_pulse: assert property (@(posedge mclk) disable iff (!resetn)
    (clk_en && exec_now && cmd_now == dce_pkg::CMD_ERASE)
    |=> flash_erase_req ##1 !flash_erase_req)
    else $error("Erase request not a single pulse");
  a_inject_len: assert property (@(posedge mclk) disable iff (!resetn)
    cpu_inject_req |-> cpu_inject_len != 2'b00)
    else $error("Injection with zero length");
endmodule // dce_engine

// ---- dce_host.sv ----
`timescale 1ns/100ps

module dce_host (
  input  wire logic dev_o,
  input  wire logic dev_oe,
  output logic      dclk,
  output logic      io
);
  logic hd;
  logic hoe;
  logic rel;

  // ********
  // Link timing
  // ********
  initial
  begin
    dclk = 1'b0;
    hd   = 1'b0;
    hoe  = 1'b0;
    rel  = 1'b0;
  end

  // Released line toggles so a stale bit never looks valid
  always #50 rel = ~rel;
  assign io = dev_oe ? dev_o : (hoe ? hd : rel);

  task automatic put_bit(input logic b);
    dclk = 1'b1;
    hd   = b;
    hoe  = 1'b1;
    #200 dclk = 1'b0;
    #200;
  endtask

  // Taken at the fall: the device drops the line soon after the last one
  task automatic get_bit(output logic b);
    hoe  = 1'b0;
    dclk = 1'b1;
    #200 b = io;
    dclk = 1'b0;
    #200;
  endtask

  // Clock stands low between frames
  task automatic xfer(input logic [7:0] c, input logic [23:0] a,
                      input int na, input int nr, output logic [15:0] rep);
    logic b;
    rep = 16'h0000;
    #13;
    for (int i = 7; i >= 0; i--)
      put_bit(c[i]);
    for (int k = na - 1; k >= 0; k--)
      for (int i = 7; i >= 0; i--)
        put_bit(a[8 * k + i]);
    for (int i = 0; i < 8 * nr; i++)
    begin
      get_bit(b);
      rep = {rep[14:0], b};
    end
    hoe = 1'b0;
    #387;
  endtask
endmodule // dce_host

// ---- debug_command_engine_test.sv ----
`timescale 1ns/100ps

module debug_command_engine_test;
  localparam logic [7:0] PART = 8'h5A; // Arbitrary value
  localparam logic [7:0] REV  = 8'h03; // Arbitrary value
  typedef struct {
    logic [7:0]  cmd;
    logic [23:0] args;
    int          na;
    int          nr;
    logic [15:0] rep;
    logic        halt;
    logic [26:0] inj;
  } dce_row_s;
  logic        mclk;
  logic        resetn;
  logic        clk_en;
  logic        dclk;
  logic        io_i;
  logic        io_o;
  logic        io_oe;
  logic [15:0] code_addr;
  logic [15:0] pc;
  logic        idle;
  logic        pm0;
  logic        osc;
  logic        ebusy;
  logic        lock;
  logic        halted;
  logic        cause;
  logic        step;
  logic        inj;
  logic        inj_rep;
  logic [1:0]  inj_len;
  logic [23:0] inj_data;
  logic        erase;
  logic [7:0]  cfg;
  logic [15:0] rep;
  logic [15:0] bpa;
  logic [26:0] last_inj;
  logic        oe_seen;
  int          step_cnt;
  int          erase_cnt;
  int          fail_count;
  int          checked;
  dce_row_s    rows[13];

  dce_engine #(.PART_CODE(PART), .REV_CODE(REV)) dce_engine_i (
    .mclk               (mclk),
    .resetn             (resetn),
    .clk_en             (clk_en),
    .debug_clock_pin    (dclk),
    .debug_io_pin_i     (io_i),
    .debug_io_pin_o     (io_o),
    .debug_io_pin_oe    (io_oe),
    .cpu_code_addr      (code_addr),
    .cpu_pc             (pc),
    .cpu_idle           (idle),
    .power_mode_0       (pm0),
    .osc_stable         (osc),
    .erase_busy         (ebusy),
    .debug_access_lock  (lock),
    .cpu_halted         (halted),
    .halt_cause_bp      (cause),
    .cpu_step_req       (step),
    .cpu_inject_req     (inj),
    .cpu_inject_replace (inj_rep),
    .cpu_inject_len     (inj_len),
    .cpu_inject_data    (inj_data),
    .flash_erase_req    (erase),
    .debug_cfg          (cfg)
  );

  dce_host dce_host_i (
    .dev_o  (io_o),
    .dev_oe (io_oe),
    .dclk   (dclk),
    .io     (io_i)
  );

  // ********
  // Helpers
  // ********
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // Upper data bits are unspecified, so only the used bytes are kept
  // Looked at mid-cycle, away from the edge that launches the outputs
  always @(negedge mclk)
  begin
    if (step === 1'b1) step_cnt++;
    if (erase === 1'b1) erase_cnt++;
    if (io_oe === 1'b1) oe_seen = 1'b1;
    if (inj === 1'b1)
      last_inj = {inj_rep, inj_len,
                  inj_data & ((24'h1 << (8 * inj_len)) - 24'h1)};
  end

  task automatic check(input string what, input logic [26:0] seen,
                       input logic [26:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #5;
  endtask

  // A refused command must never turn the data pin around
  task automatic cmd(input logic [7:0] c, input logic [23:0] a,
                     input int na, input int nr, input logic [15:0] exp);
    oe_seen = 1'b0;
    dce_host_i.xfer(c, a, na, nr, rep);
    if (nr > 0)
      check("reply", rep, exp);
    else
      check("refused oe", oe_seen, 1'b0);
  endtask

  task automatic wait_halt;
    int n;
    n = 0;
    while (halted !== 1'b1 && n < 20)
    begin
      cyc(1);
      n++;
    end
    if (halted !== 1'b1)
    begin
      fail_count++;
      report_and_stop();
    end
  endtask

  initial
  begin
    repeat (100000) @(posedge mclk);
    fail_count++;
    report_and_stop();
  end

  // ********
  // Main sequence
  // ********
  initial
  begin
    {resetn, idle, ebusy, oe_seen} = 4'h0;
    {clk_en, pm0, osc, lock} = 4'hF;
    code_addr = 16'hFFFF;
    pc = 16'h1234;
    last_inj = 27'h000_0000;
    {step_cnt, erase_cnt, fail_count, checked} = 128'h0;
    // Host waits for halt before stepping or injecting
    rows = '{
      '{dce_pkg::CMD_STATUS, 24'h0, 0, 1, 16'h0092, 1'b0, 27'h0},
      '{dce_pkg::CMD_ID, 24'h0, 0, 2, {PART, REV}, 1'b0, 27'h0},
      '{dce_pkg::CMD_RD_CFG, 24'h0, 0, 1, 16'h0000, 1'b0, 27'h0},
      '{dce_pkg::CMD_WR_CFG, 24'hA6, 1, 1, 16'h0092, 1'b0, 27'h0},
      '{dce_pkg::CMD_RD_CFG, 24'h0, 0, 1, 16'h00A6, 1'b0, 27'h0},
      '{dce_pkg::CMD_PC, 24'h0, 0, 2, 16'h1234, 1'b0, 27'h0},
      '{dce_pkg::CMD_HALT, 24'h0, 0, 1, 16'h0092, 1'b1, 27'h0},
      '{dce_pkg::CMD_STATUS, 24'h0, 0, 1, 16'h00B2, 1'b1, 27'h0},
      '{8'h55, 24'hA5, 1, 1, 16'h00B2, 1'b1, 27'h100_00A5},
      '{8'h57, 24'h11_2233, 3, 1, 16'h00B2, 1'b1, 27'h311_2233},
      '{8'h66, 24'h4455, 2, 1, 16'h00B2, 1'b1, 27'h600_4455},
      '{dce_pkg::CMD_STEP, 24'h0, 0, 1, 16'h00B2, 1'b1, 27'h600_4455},
      '{dce_pkg::CMD_RESUME, 24'h0, 0, 1, 16'h00B2, 1'b0, 27'h600_4455}
    };
    cyc(6);
    resetn = 1'b1;
    cyc(4);
    check("cfg reset", cfg, 8'h00);
    foreach (rows[r])
    begin
      cmd(rows[r].cmd, rows[r].args, rows[r].na, rows[r].nr,
          rows[r].rep);
      check("halted", halted, rows[r].halt);
      check("inject", last_inj, rows[r].inj);
    end
    check("step count", step_cnt, 1);
    check("cfg", cfg, 8'hA6);
    for (int s = 0; s < 4; s++)
    begin
      bpa = 16'h1234 * (s + 1);
      cmd(dce_pkg::CMD_BP, {3'b101, s[1:0], 3'b100, bpa}, 3, 1,
          (s == 0) ? 16'h0092 : 16'h009A);
      code_addr = {bpa[7:0], bpa[15:8]};
      cyc(8);
      check("swapped addr", halted, 1'b0);
      code_addr = bpa;
      wait_halt();
      check("cause", cause, 1'b1);
      code_addr = 16'hFFFF;
      cmd(dce_pkg::CMD_RESUME, 24'h0, 0, 1, 16'h00BA);
      check("resumed", halted, 1'b0);
    end
    cmd(dce_pkg::CMD_BP, 24'h00_1234, 3, 1, 16'h009A);
    code_addr = 16'h1234;
    cyc(8);
    check("disabled slot", halted, 1'b0);
    // Enable low keeps a hit from being taken, though the compare still runs
    clk_en = 1'b0;
    code_addr = 16'h2468;
    cyc(8);
    check("frozen", halted, 1'b0);
    clk_en = 1'b1;
    wait_halt();
    code_addr = 16'hFFFF;
    cmd(dce_pkg::CMD_RESUME, 24'h0, 0, 1, 16'h00BA);
    code_addr = 16'hFFFF;
    cmd(8'hFF, 24'h0, 0, 0, 16'h0000);
    cmd(dce_pkg::CMD_INJECT, 24'h0, 0, 0, 16'h0000);
    check("zero length", last_inj, 27'h600_4455);
    cmd(dce_pkg::CMD_STATUS, 24'h0, 0, 1, 16'h009A);
    lock = 1'b0;
    cmd(dce_pkg::CMD_RESUME, 24'h0, 0, 1, 16'h009A);
    cmd(dce_pkg::CMD_HALT, 24'h0, 0, 0, 16'h0000);
    check("locked halt", halted, 1'b0);
    cmd(dce_pkg::CMD_STATUS, 24'h0, 0, 1, 16'h009E);
    cmd(dce_pkg::CMD_ID, 24'h0, 0, 2, {PART, REV});
    cmd(dce_pkg::CMD_ERASE, 24'h0, 0, 1, 16'h009E);
    check("erase pulse", erase_cnt, 1);
    ebusy = 1'b1;
    cmd(dce_pkg::CMD_STATUS, 24'h0, 0, 1, 16'h001E);
    {idle, pm0, osc} = 3'b100;
    cmd(dce_pkg::CMD_STATUS, 24'h0, 0, 1, 16'h004C);
    {idle, pm0, osc} = 3'b011;
    ebusy = 1'b0;
    cmd(dce_pkg::CMD_STATUS, 24'h0, 0, 1, 16'h009E);
    lock = 1'b1;
    resetn = 1'b0;
    cyc(2);
    check("cfg in reset", cfg, 8'h00);
    resetn = 1'b1;
    code_addr = 16'h2468;
    cyc(8);
    check("slots cleared", halted, 1'b0);
    cmd(dce_pkg::CMD_STATUS, 24'h0, 0, 1, 16'h0092);
    report_and_stop();
  end
endmodule // debug_command_engine_test
